// ---- hdl/clock_switch_map.vh ----
// register map, field positions, reset values and timing constants of the clock switch
`ifndef CLOCK_SWITCH_MAP_VH
`define CLOCK_SWITCH_MAP_VH

// register byte addresses
`define MAIN_SEL_ADDR      32'h4000401C
`define CPU_SEL_ADDR       32'h40004020
`define HF_TRIM_ADDR       32'h40004024
`define INT_STATUS_ADDR    32'h40004028
`define INT_MASK_ADDR      32'h4000402C
`define KHZ_CAL_ADDR       32'h40004030

// field positions
`define MAIN_SOURCE_BIT    0
`define CRYSTAL_ENABLE_BIT 1
`define CPU_FAST_BIT       0
`define EV_FAILOVER_BIT    0
`define EV_RECOVER_BIT     1
`define ST_ACTIVE_SRC_BIT  8
`define ST_CPU_FAST_BIT    9
`define ST_FLASH_BIT       10
`define ST_XTAL_OK_BIT     11

// reset values
`define MAIN_SEL_RESET     2'h0
`define CPU_SEL_RESET      1'h0
`define HF_TRIM_RESET      5'h00
`define INT_MASK_RESET     2'h0
`define KHZ_CAL_RESET      10'h064

// frequencies in kHz
`define CLK_KHZ            50000
`define HF_RC_KHZ          12000
`define HF_STEP_KHZ        500
`define XTAL_KHZ           24000
`define LF_RC_KHZ          10
// fractional-N denominator of the 1 kHz divider
`define KHZ_DEN            1000

`endif

// ---- hdl/tick_gen.v ----
// phase accumulator that turns the system clock into an enable pulse of a given rate
`timescale 1ns/1ps
module tick_gen #(
   parameter ACC_W   = 18,
   parameter MODULUS = 50000
) (
   input  wire             clk,
   input  wire             rst,
   input  wire             run,
   input  wire [ACC_W-1:0] step,
   output reg              tick
);
   localparam [ACC_W-1:0] MOD_W = MODULUS;

   reg  [ACC_W-1:0] acc;
   wire [ACC_W-1:0] sum = acc + step;

   // fractional rate: average spacing is MODULUS/step cycles, jitter one cycle
   always @(posedge clk) begin
      if (rst) begin
         acc  <= {ACC_W{1'b0}};
         tick <= 1'b0;
      end else if (!run) begin
         tick <= 1'b0;
      end else if (sum >= MOD_W) begin
         acc  <= sum - MOD_W;
         tick <= 1'b1;
      end else begin
         acc  <= sum;
         tick <= 1'b0;
      end
   end
endmodule // tick_gen

// ---- hdl/clock_switch.v ----
// system, peripheral, cpu, ram and reference clock enables with crystal failover
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "clock_switch_map.vh"
module clock_switch (
   input  wire        clk,
   input  wire        rst,
   input  wire [31:0] addr,
   input  wire [31:0] wdata,
   input  wire        wr,
   input  wire        rd,
   output reg  [31:0] rdata,
   input  wire        xtal_ok,
   input  wire        watch_xtal_in,
   input  wire        lf_rc_on,
   input  wire        flash_busy,
   output reg         sys_clk_en,
   output reg         periph_clk_en,
   output reg         cpu_core_clock,
   output reg         ram_clk_en,
   output reg         khz_reference_clock,
   output reg         watch_crystal_clock,
   output reg         crystal_active,
   output reg         nmi,
   output reg         irq
);
   localparam [17:0] HF_BASE = `HF_RC_KHZ;
   localparam [17:0] HF_STEP = `HF_STEP_KHZ;
   localparam [17:0] XT_STEP = `XTAL_KHZ;
   localparam [17:0] LF_STEP = `LF_RC_KHZ;
   localparam [9:0]  KDEN    = `KHZ_DEN;

   function hit;
      input [31:0] a;
      input [31:0] target;
      begin
         hit = (a == target);
      end
   endfunction

   // software registers
   reg  [1:0]  main_clock_source_select;
   reg         cpu_clock_speed_select;
   reg  [4:0]  hf_trim;
   reg  [1:0]  int_status;
   reg  [1:0]  int_mask;
   reg  [9:0]  khz_cal;

   // pin synchronisers
   reg  [1:0]  xtal_ok_sync;
   reg  [1:0]  watch_sync;
   reg         watch_prev;
   reg  [2:0]  sync_fill;

   // clock generation state
   reg         active_src;
   reg         cpu_fast_act;
   reg         flash_act;
   reg         sys_phase;
   reg  [9:0]  khz_acc;
   reg         xtal_ok_prev;
   reg         switch_gap;

   wire        hf_tick;
   wire        xt_tick;
   wire        lf_tick;
   wire        xtal_good = xtal_ok_sync[1];
   wire        want_xtal = main_clock_source_select[`MAIN_SOURCE_BIT] |
                           main_clock_source_select[`CRYSTAL_ENABLE_BIT];
   wire        fail_now  = want_xtal & ~xtal_good;
   wire        next_src  = want_xtal & xtal_good;
   // the synced pin reads a false low until the chain has filled after reset
   wire        sync_ready = sync_fill[2];
   wire        src_tick  = (active_src ? xt_tick : hf_tick) & ~switch_gap;
   // end of a full peripheral period: the only place a source or mode may change, except the drop to rc on failover
   wire        boundary  = src_tick & sys_phase;
   // five-bit trim is signed, so it is sign-extended before scaling
   wire [17:0] hf_step_k = HF_BASE + {{13{hf_trim[4]}}, hf_trim} * HF_STEP;
   wire [10:0] khz_sum   = {1'b0, khz_acc} + {1'b0, khz_cal};

   // register strobes
   wire        wr_main   = wr & hit(addr, `MAIN_SEL_ADDR);
   wire        wr_cpu    = wr & hit(addr, `CPU_SEL_ADDR);
   wire        wr_trim   = wr & hit(addr, `HF_TRIM_ADDR);
   wire        wr_cal    = wr & hit(addr, `KHZ_CAL_ADDR);
   wire        wr_mask   = wr & hit(addr, `INT_MASK_ADDR);
   wire        rd_status = rd & hit(addr, `INT_STATUS_ADDR);
   wire        ev_fail   = fail_now & active_src;
   wire        ev_recov  = xtal_good & ~xtal_ok_prev & sync_ready;

   tick_gen #(.ACC_W(18), .MODULUS(`CLK_KHZ)) u_hf_rc (
      .clk  (clk),
      .rst  (rst),
      .run  (1'b1),
      .step (hf_step_k),
      .tick (hf_tick)
   );

   tick_gen #(.ACC_W(18), .MODULUS(`CLK_KHZ)) u_xtal (
      .clk  (clk),
      .rst  (rst),
      .run  (xtal_good),
      .step (XT_STEP),
      .tick (xt_tick)
   );

   tick_gen #(.ACC_W(18), .MODULUS(`CLK_KHZ)) u_lf_rc (
      .clk  (clk),
      .rst  (rst),
      .run  (lf_rc_on),
      .step (LF_STEP),
      .tick (lf_tick)
   );

   always @(posedge clk) begin
      if (rst) begin
         xtal_ok_sync <= 2'h0;
         watch_sync   <= 2'h0;
         watch_prev   <= 1'b0;
         xtal_ok_prev <= 1'b0;
         sync_fill    <= 3'h0;
      end else begin
         xtal_ok_sync <= {xtal_ok_sync[0], xtal_ok};
         watch_sync   <= {watch_sync[0], watch_xtal_in};
         watch_prev   <= watch_sync[1];
         xtal_ok_prev <= xtal_good;
         sync_fill    <= {sync_fill[1:0], 1'b1};
      end
   end

   // register writes; a failover clears the source request so it cannot bounce back
   always @(posedge clk) begin
      if (rst) begin
         main_clock_source_select <= `MAIN_SEL_RESET;
         cpu_clock_speed_select   <= `CPU_SEL_RESET;
         hf_trim                  <= `HF_TRIM_RESET;
         int_mask                 <= `INT_MASK_RESET;
         khz_cal                  <= `KHZ_CAL_RESET;
      end else begin
         if (fail_now) begin
            main_clock_source_select <= 2'h0;
         end else if (wr_main) begin
            main_clock_source_select <= wdata[1:0];
         end
         if (wr_cpu) begin
            cpu_clock_speed_select <= wdata[`CPU_FAST_BIT];
         end
         if (wr_trim) begin
            hf_trim <= wdata[4:0];
         end
         if (wr_mask) begin
            int_mask <= wdata[1:0];
         end
         if (wr_cal) begin
            khz_cal <= wdata[9:0];
         end
      end
   end

   // sticky events: a new event in the clearing read's cycle survives
   always @(posedge clk) begin
      if (rst) begin
         int_status <= 2'h0;
      end else begin
         int_status <= (rd_status ? 2'h0 : int_status) | {ev_recov, ev_fail};
      end
   end

   // source and cpu mode change only at a peripheral period boundary, except the drop to rc on failover
   always @(posedge clk) begin
      if (rst) begin
         active_src   <= 1'b0;
         cpu_fast_act <= 1'b0;
         flash_act    <= 1'b0;
         sys_phase    <= 1'b0;
      end else begin
         if (fail_now) begin
            // dead crystal gives no edges to wait for, so drop it at once
            active_src <= 1'b0;
            sys_phase  <= 1'b0;
         end else begin
            if (src_tick) begin
               sys_phase <= ~sys_phase;
            end
            if (boundary) begin
               active_src <= next_src;
            end
         end
         // fast mode and flash force change at the same boundary
         if (boundary) begin
            cpu_fast_act <= cpu_clock_speed_select;
            flash_act    <= flash_busy;
         end
      end
   end

   // one dead cycle after a source change keeps the two tick trains apart
   always @(posedge clk) begin
      if (rst) begin
         switch_gap <= 1'b0;
      end else begin
         switch_gap <= boundary & ~fail_now & (active_src ^ next_src);
      end
   end

   // fractional-N divider from the 10 kHz rc to the 1 kHz reference
   always @(posedge clk) begin
      if (rst) begin
         khz_acc <= 10'h000;
      end else if (lf_tick) begin
         if (khz_sum >= {1'b0, KDEN}) begin
            khz_acc <= khz_sum[9:0] - KDEN;
         end else begin
            khz_acc <= khz_sum[9:0];
         end
      end
   end

   reg next_cpu;

   always @* begin
      if (flash_act) begin
         // 12 MHz: the system clock on rc, the peripheral clock on crystal
         next_cpu = active_src ? (src_tick & sys_phase) : src_tick;
      end else if (cpu_fast_act) begin
         next_cpu = src_tick;
      end else begin
         next_cpu = src_tick & sys_phase;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         sys_clk_en          <= 1'b0;
         periph_clk_en       <= 1'b0;
         cpu_core_clock      <= 1'b0;
         ram_clk_en          <= 1'b0;
         khz_reference_clock <= 1'b0;
         watch_crystal_clock <= 1'b0;
         crystal_active      <= 1'b0;
         nmi                 <= 1'b0;
         irq                 <= 1'b0;
      end else begin
         sys_clk_en          <= src_tick & ~fail_now;
         periph_clk_en       <= boundary & ~fail_now;
         cpu_core_clock      <= next_cpu & ~fail_now;
         // bus clock follows the cpu in fast mode; ram runs at system rate otherwise
         ram_clk_en          <= (cpu_fast_act ? next_cpu : src_tick) & ~fail_now;
         khz_reference_clock <= lf_tick & (khz_sum >= {1'b0, KDEN});
         watch_crystal_clock <= watch_sync[1] & ~watch_prev;
         crystal_active      <= active_src & ~fail_now;
         // nmi is not maskable, the mask only gates irq
         nmi                 <= int_status[`EV_FAILOVER_BIT] | ev_fail;
         irq                 <= |(int_status & int_mask);
      end
   end

   // read data stand in the cycle after the strobe; unmapped reads give zero
   always @(posedge clk) begin
      if (rst) begin
         rdata <= 32'h00000000;
      end else if (rd) begin
         rdata <= 32'h00000000;
         if (hit(addr, `MAIN_SEL_ADDR)) begin
            rdata[1:0] <= main_clock_source_select;
         end
         if (hit(addr, `CPU_SEL_ADDR)) begin
            rdata[`CPU_FAST_BIT] <= cpu_clock_speed_select;
         end
         if (hit(addr, `HF_TRIM_ADDR)) begin
            rdata[4:0] <= hf_trim;
         end
         if (hit(addr, `INT_STATUS_ADDR)) begin
            rdata[1:0]                <= int_status;
            rdata[`ST_ACTIVE_SRC_BIT] <= active_src;
            rdata[`ST_CPU_FAST_BIT]   <= cpu_fast_act;
            rdata[`ST_FLASH_BIT]      <= flash_act;
            rdata[`ST_XTAL_OK_BIT]    <= xtal_good;
         end
         if (hit(addr, `INT_MASK_ADDR)) begin
            rdata[1:0] <= int_mask;
         end
         if (hit(addr, `KHZ_CAL_ADDR)) begin
            rdata[9:0] <= khz_cal;
         end
      end
   end
endmodule // clock_switch

// ---- tb/clock_switch_monitor.sv ----
// checker for the clock switch enables, failover and reset state
`timescale 1ns/1ps
module clock_switch_monitor (
   input wire        clk,
   input wire        rst,
   input wire        rd,
   input wire [31:0] rdata,
   input wire        xtal_ok,
   input wire        lf_rc_on,
   input wire        sys_clk_en,
   input wire        periph_clk_en,
   input wire        cpu_core_clock,
   input wire        ram_clk_en,
   input wire        khz_reference_clock,
   input wire        crystal_active,
   input wire        nmi,
   input wire        irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence xtal_lost;
      $fell(xtal_ok) ##0 crystal_active;
   endsequence
   sequence on_rc_nmi;
      !crystal_active && nmi;
   endsequence
   chk_failover_nmi: assert property (xtal_lost |-> ##[2:6] on_rc_nmi)
      else $error("no failover to rc with nmi");
   chk_stay_rc: assert property (!xtal_ok [*8] |-> !crystal_active)
      else $error("crystal active while crystal bad");
   chk_nmi_holds: assert property (nmi && !rd && !$past(rd) && !$past(rd, 2) |=> nmi)
      else $error("nmi dropped without status read");
   chk_periph_in_sys: assert property (periph_clk_en |-> sys_clk_en)
      else $error("peripheral pulse without system pulse");
   chk_cpu_in_sys: assert property (cpu_core_clock |-> sys_clk_en)
      else $error("cpu pulse without system pulse");
   chk_ram_in_sys: assert property (ram_clk_en |-> sys_clk_en)
      else $error("ram pulse without system pulse");
   chk_sys_no_runt: assert property (sys_clk_en |=> !sys_clk_en)
      else $error("system pulses back to back");
   chk_khz_stops: assert property (!lf_rc_on [*6] |-> !khz_reference_clock)
      else $error("reference pulse while rc off");
   chk_reset_quiet: assert property (disable iff (1'b0)
      rst |=> (rdata == 32'h0 && !nmi && !irq && !crystal_active))
      else $error("outputs not quiet after reset");
endmodule // clock_switch_monitor

// ---- tb/osc_flash_model.sv ----
// far side: crystal, watch crystal, low-frequency rc and flash controller
`timescale 1ns/1ps
module osc_flash_model (
   input  wire xtal_fail,
   input  wire deep_sleep,
   input  wire flash_op,
   output wire xtal_ok,
   output reg  watch_xtal_in,
   output wire lf_rc_on,
   output wire flash_busy
);
   initial watch_xtal_in = 1'b0;
   // free-running on its own timebase; period shortened to keep the run brief
   always #300.3 watch_xtal_in = ~watch_xtal_in;
   assign xtal_ok    = !xtal_fail;
   assign lf_rc_on   = !deep_sleep;
   assign flash_busy = flash_op;
endmodule // osc_flash_model

// ---- tb/tb.sv ----
// self-checking bench for the clock switch
`timescale 1ns/1ps
`include "clock_switch_map.vh"
module tb;
   reg  [31:0] addr = 32'h0, wdata = 32'h0, seed = 32'h8886;
   reg         clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
   reg         xtal_fail = 1'b0, deep_sleep = 1'b0, flash_op = 1'b0;
   wire [31:0] rdata;
   wire        xtal_ok, watch_xtal_in, lf_rc_on, flash_busy, sys_clk_en, periph_clk_en;
   wire        cpu_core_clock, ram_clk_en, khz_reference_clock, watch_crystal_clock;
   wire        crystal_active, nmi, irq;
   reg  [63:0] exp_q[$];
   reg  [63:0] e;
   integer     fail_count = 0, cmp_count = 0, m, c, f, t;
   integer     n_sys = 0, n_per = 0, n_cpu = 0, n_ram = 0, n_khz = 0, n_wat = 0;
   always #10 clk = ~clk;
   clock_switch i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .xtal_ok(xtal_ok), .watch_xtal_in(watch_xtal_in), .lf_rc_on(lf_rc_on),
      .flash_busy(flash_busy), .sys_clk_en(sys_clk_en), .periph_clk_en(periph_clk_en),
      .cpu_core_clock(cpu_core_clock), .ram_clk_en(ram_clk_en),
      .khz_reference_clock(khz_reference_clock), .watch_crystal_clock(watch_crystal_clock),
      .crystal_active(crystal_active), .nmi(nmi), .irq(irq));
   osc_flash_model i_far (.xtal_fail(xtal_fail), .deep_sleep(deep_sleep),
      .flash_op(flash_op), .xtal_ok(xtal_ok), .watch_xtal_in(watch_xtal_in),
      .lf_rc_on(lf_rc_on), .flash_busy(flash_busy));
   function [31:0] xs(input [31:0] v);
      reg [31:0] x;
      begin
         x = v ^ (v << 13);
         x = x ^ (x >> 17);
         xs = x ^ (x << 5);
      end
   endfunction
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // oscillators jitter by a cycle, so pulse counts get a small margin
   task approx(input string nm, input integer got, input integer exp);
      check(nm, (got >= exp - 2 && got <= exp + 2) ? exp : got, exp);
   endtask
   task wreg(input [31:0] a, input [31:0] d);
      begin
         @(posedge clk);
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask
   task rreg(input [31:0] a, input [31:0] x, input [31:0] k);
      begin
         @(posedge clk);
         exp_q.push_back({x, k});
         addr <= a;
         rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
      end
   endtask
   task settle(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   task measure(input integer n);
      begin
         @(negedge clk);
         n_sys = 0;
         n_per = 0;
         n_cpu = 0;
         n_ram = 0;
         n_khz = 0;
         n_wat = 0;
         settle(n);
      end
   endtask
   task stop_test;
      begin
         $display("compares %0d mismatches %0d", cmp_count, fail_count);
         if (fail_count == 0 && cmp_count > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   always @(posedge clk) begin
      n_sys <= n_sys + sys_clk_en;
      n_per <= n_per + periph_clk_en;
      n_cpu <= n_cpu + cpu_core_clock;
      n_ram <= n_ram + ram_clk_en;
      n_khz <= n_khz + khz_reference_clock;
      n_wat <= n_wat + watch_crystal_clock;
      rd_d <= rd;
      if (rd_d && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         check("rdata", rdata & e[31:0], e[63:32] & e[31:0]);
      end
   end
   initial begin
      repeat (100000) @(posedge clk);
      fail_count = fail_count + 1;
      stop_test;
   end
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      settle(2);
      check("source", crystal_active, 1'b0);
      rreg(`MAIN_SEL_ADDR, 0, 3);
      rreg(`CPU_SEL_ADDR, 0, 1);
      rreg(`HF_TRIM_ADDR, 0, 32'h1F);
      rreg(`INT_MASK_ADDR, 0, 3);
      rreg(`KHZ_CAL_ADDR, 32'h64, 32'h3FF);
      rreg(32'h40004034, 0, 32'hFFFFFFFF);
      rreg(`INT_STATUS_ADDR, 32'h800, 32'h803);
      $display("reset values done");
      for (m = 0; m < 3; m = m + 1)
         for (c = 0; c < 2; c = c + 1)
            for (f = 0; f < 2; f = f + 1) begin
               wreg(`MAIN_SEL_ADDR, m);
               wreg(`CPU_SEL_ADDR, c);
               flash_op <= f;
               measure(30);
               measure(500);
               t = (m != 0) ? 240 : 120;
               approx("sys", n_sys, t);
               approx("periph", n_per, t / 2);
               approx("cpu", n_cpu, f ? 120 : (c ? t : t / 2));
               if (!f) approx("ram", n_ram, t);
               check("active", crystal_active, m != 0);
               rreg(`INT_STATUS_ADDR, {f[0], c[0], m != 0} << 8 | 32'h800, 32'hF00);
            end
      wreg(`MAIN_SEL_ADDR, 0);
      wreg(`CPU_SEL_ADDR, 0);
      flash_op <= 1'b0;
      $display("clock modes done");
      repeat (3) begin
         seed = xs(seed);
         t = seed[4] ? seed[4:0] - 32 : seed[4:0];
         wreg(`HF_TRIM_ADDR, seed[4:0]);
         measure(30);
         measure(500);
         approx("trim", n_sys, 120 + 5 * t);
      end
      wreg(`HF_TRIM_ADDR, 0);
      $display("trim done");
      wreg(`INT_MASK_ADDR, 3);
      wreg(`MAIN_SEL_ADDR, 1);
      settle(30);
      check("xtal on", crystal_active, 1'b1);
      xtal_fail <= 1'b1;
      settle(10);
      check("failover", {crystal_active, nmi, irq}, 3'b011);
      rreg(`MAIN_SEL_ADDR, 0, 3);
      rreg(`INT_STATUS_ADDR, 1, 32'h901);
      settle(4);
      check("nmi clear", {nmi, irq}, 2'b00);
      wreg(`MAIN_SEL_ADDR, 1);
      settle(30);
      check("refused", crystal_active, 1'b0);
      wreg(`INT_MASK_ADDR, 1);
      xtal_fail <= 1'b0;
      settle(10);
      check("masked", irq, 1'b0);
      wreg(`INT_MASK_ADDR, 2);
      settle(2);
      check("unmasked", irq, 1'b1);
      rreg(`INT_STATUS_ADDR, 32'h802, 32'h803);
      $display("failover done");
      wreg(`KHZ_CAL_ADDR, 32'h3E8);
      measure(5000);
      measure(25000);
      approx("khz", n_khz, 5);
      approx("watch", n_wat, 832);
      deep_sleep <= 1'b1;
      measure(10);
      measure(12000);
      check("khz stop", n_khz, 0);
      $display("reference clocks done");
      stop_test;
   end
endmodule // tb
bind clock_switch clock_switch_monitor i_mon (.clk(clk), .rst(rst), .rd(rd), .rdata(rdata),
   .xtal_ok(xtal_ok), .lf_rc_on(lf_rc_on), .sys_clk_en(sys_clk_en),
   .periph_clk_en(periph_clk_en), .cpu_core_clock(cpu_core_clock), .ram_clk_en(ram_clk_en),
   .khz_reference_clock(khz_reference_clock), .crystal_active(crystal_active),
   .nmi(nmi), .irq(irq));
